// ==== shared/pio_defs.svh ====
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// Register offsets on the plain register port
`define PIO_OFS_A_DATA 8'h00
`define PIO_OFS_B_DATA 8'h01
`define PIO_OFS_C_DATA 8'h02
`define PIO_OFS_D_DATA 8'h03
`define PIO_OFS_A_DIR  8'h04
`define PIO_OFS_B_DIR  8'h05
`define PIO_OFS_C_DIR  8'h06
`define PIO_OFS_D_DIR  8'h07
`define PIO_OFS_E_DATA 8'h08
`define PIO_OFS_F_DATA 8'h09
`define PIO_OFS_G_DATA 8'h0a
`define PIO_OFS_H_DATA 8'h0b
`define PIO_OFS_E_DIR  8'h0c
`define PIO_OFS_F_DIR  8'h0d
`define PIO_OFS_G_DIR  8'h0e
`define PIO_OFS_H_DIR  8'h0f

// Implemented bits per port
`define PIO_W_A 8
`define PIO_W_B 8
`define PIO_W_C 6
`define PIO_W_D 8
`define PIO_W_E 8
`define PIO_W_F 7
`define PIO_W_G 3
`define PIO_W_H 2

// Field positions and reset values
`define PIO_SYSCLK_BIT 7
`define PIO_SYSCLK_PIN 2
`define PIO_DIR_RST    8'h00
`define PIO_B_CHANNELS 5'h08
`define PIO_SYNC_STAGES 2

`endif

// ==== shared/pio_pkg.sv ====
`default_nettype none

package pio_pkg;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pio_bus_req_type;

  // All fifty pins, one field per port
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [5:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [6:0] f;
    logic [2:0] g;
    logic [1:0] h;
  } pio_pad_type;

endpackage

`default_nettype wire

// ==== sim/pio_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pio_board_model (
  input  wire pio_pkg::pio_pad_type pad_out,
  input  wire pio_pkg::pio_pad_type pad_oe,
  input  wire pio_pkg::pio_pad_type ext,
  output var  pio_pkg::pio_pad_type pad_in
);
  import pio_pkg::*;

  // A driven pin shows the device level, a released pin shows the board
  // The board is assumed never to fight a driving device pin
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

`default_nettype wire

// ==== sim/pio_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module pio_top_bench;
  import pio_pkg::*;

  logic            clk     = 1'b0;
  logic            rst_n   = 1'b0;
  pio_bus_req_type bus     = '0;
  logic [4:0]      sel     = 5'h1f;
  pio_pad_type     ext     = '0;
  logic [7:0]      rd_data;
  pio_pad_type     pad_in;
  pio_pad_type     pad_out;
  pio_pad_type     pad_oe;
  int              n_fail  = 0;
  int              checked = 0;
  logic [7:0]      lm [16] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff,
                               8'hff, 8'h7f, 8'h07, 8'h03, 8'hff, 8'h7f, 8'h07, 8'h03};

  // Bus clock, 50 ns period
  always #25 clk = ~clk;

  pio_top DUT (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .bus_req                  (bus),
    .rd_data                  (rd_data),
    .converter_channel_select (sel),
    .pad_in                   (pad_in),
    .pad_out                  (pad_out),
    .pad_oe                   (pad_oe)
  );

  pio_board_model BRD (
    .pad_out (pad_out),
    .pad_oe  (pad_oe),
    .ext     (ext),
    .pad_in  (pad_in)
  );

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe; the next call waits a fresh edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask

  // Read data stands one cycle only, then drops back to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    @(negedge clk);
    chk(what, exp, rd_data);
    @(negedge clk);
    chk("rd idle", 8'h00, rd_data);
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr    <= 1'b0;
    bus.rd    <= 1'b1;
    @(posedge clk);
    bus.rd    <= 1'b0;
    @(negedge clk);
    chk(what, exp, rd_data);
  endtask

  // Pin levels pass two sync stages, so let them land before reading
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("oe reset", 64'h0, pad_oe);
    rd(8'h04, 8'h00, "dir a");
    rd(8'h05, 8'h00, "dir b");
    rd(8'h06, 8'h00, "dir c");
    @(posedge clk);
    ext.a <= 8'hc3;
    ext.b <= 8'h96;
    ext.c <= 6'h2d;
    wr(8'h00, 8'h5a);
    wr(8'h01, 8'h55);
    settle();
    rd(8'h00, 8'hc3, "a pin");
    wr_rd(8'h00, 8'h5a, 8'hc3, "a pin after write");
    rd(8'h02, 8'h2d, "c pin");
    chk("a latch", 8'h5a, pad_out.a);
    wr(8'h04, 8'hf0);
    @(negedge clk);
    chk("a oe", 8'hf0, pad_oe.a);
    rd(8'h00, 8'h53, "a mixed");
    // Converter claims port B pin 2
    @(posedge clk);
    sel <= 5'd2;
    wr(8'h05, 8'h0f);
    settle();
    chk("b oe", 8'h0b, pad_oe.b);
    rd(8'h01, 8'h95, "b conv out");
    wr(8'h05, 8'hf0);
    settle();
    rd(8'h01, 8'h52, "b conv in");
    @(posedge clk);
    sel <= 5'd8;
    settle();
    rd(8'h01, 8'h56, "b plain");
    // Reset in mid-run keeps latches but releases pins
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk("oe in reset", 64'h0, pad_oe);
    chk("a kept", 8'h5a, pad_out.a);
    chk("b kept", 8'h55, pad_out.b);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Whole map, latches first, clock-out enable kept off
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        if (i[2] == p[0]) begin
          wr(i[7:0], (i == 6) ? 8'h7f : 8'hff);
        end
      end
    end
    for (int i = 0; i < 16; i++) begin
      rd(i[7:0], lm[i], "map");
    end
    chk("all oe", {50{1'b1}}, pad_oe);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00, "unmapped");
    // Clock out on port C pin 2
    wr(8'h06, 8'h80);
    @(posedge clk);
    #1;
    chk("clk out hi", 1'b1, pad_out.c[2]);
    chk("c oe", 6'h04, pad_oe.c);
    @(negedge clk);
    #1;
    chk("clk out lo", 1'b0, pad_out.c[2]);
    rd(8'h06, 8'h80, "dir c clk");
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule

`default_nettype wire

// ==== verilog/pio_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

module pio_port #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr_data_en,
  input  wire logic         wr_dir_en,
  input  wire logic [W-1:0] wr_val,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] analog,
  output logic      [W-1:0] latch_q,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] rd_val
);
  import pio_pkg::*;

  logic [W-1:0] latch_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] level;

  // Latch has no reset: its content survives a reset untouched
  always_ff @(posedge clk) begin
    if (wr_data_en) begin
      latch_reg <= wr_val;
    end
  end

  // Direction comes out of reset as all inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= W'(`PIO_DIR_RST);
    end else if (wr_dir_en) begin
      dir_reg <= wr_val;
    end
  end

  // Pin levels are synchronised before software sees them
  pio_sync #(.W(W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (level)
  );

  // Converter pins never drive; reads pick latch, pin or zero
  assign pin_oe  = dir_reg & ~analog;
  assign rd_val  = (dir_reg & latch_reg) | (~dir_reg & ~analog & level);
  assign latch_q = latch_reg;
  assign dir_q   = dir_reg;
endmodule
`default_nettype wire

// ==== verilog/pio_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

module pio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import pio_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // Two stages; only the second stage is ever read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule
`default_nettype wire

// ==== verilog/pio_top.sv ====
// Function
// - Direction bit one enables pin driver
// - Reset clears port A and B directions
// - Reset leaves data latches unchanged
// - Output bit reads back its latch
// - Input bit reads the pin level
// - Data writes always update the latch
// - Latch writes never disturb input reads
// - Converter pin as input reads zero
// - Converter pins ignore direction for driving
// - Channel select decides converter or GPIO
// - Sixteen registers at offsets 0x00 to 0x0F
// - Fifty pins across the port bank
// - Port C holds six data bits
// - Port C direction bit 7 drives clock
// - Reset clears port C direction and enable
`timescale 1ns/1ps
`default_nettype none
`include "pio_defs.svh"

module pio_top (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire pio_pkg::pio_bus_req_type bus_req,
  output logic [7:0]                    rd_data,
  input  wire logic [4:0]               converter_channel_select,
  input  wire pio_pkg::pio_pad_type     pad_in,
  output var  pio_pkg::pio_pad_type     pad_out,
  output var  pio_pkg::pio_pad_type     pad_oe
);
  import pio_pkg::*;

  // Address decode
  wire       wr = bus_req.wr;
  wire [7:0] wv = bus_req.wdata;
  wire       sel_a_data = (bus_req.addr == `PIO_OFS_A_DATA);
  wire       sel_b_data = (bus_req.addr == `PIO_OFS_B_DATA);
  wire       sel_c_data = (bus_req.addr == `PIO_OFS_C_DATA);
  wire       sel_d_data = (bus_req.addr == `PIO_OFS_D_DATA);
  wire       sel_a_dir  = (bus_req.addr == `PIO_OFS_A_DIR);
  wire       sel_b_dir  = (bus_req.addr == `PIO_OFS_B_DIR);
  wire       sel_c_dir  = (bus_req.addr == `PIO_OFS_C_DIR);
  wire       sel_d_dir  = (bus_req.addr == `PIO_OFS_D_DIR);
  wire       sel_e_data = (bus_req.addr == `PIO_OFS_E_DATA);
  wire       sel_f_data = (bus_req.addr == `PIO_OFS_F_DATA);
  wire       sel_g_data = (bus_req.addr == `PIO_OFS_G_DATA);
  wire       sel_h_data = (bus_req.addr == `PIO_OFS_H_DATA);
  wire       sel_e_dir  = (bus_req.addr == `PIO_OFS_E_DIR);
  wire       sel_f_dir  = (bus_req.addr == `PIO_OFS_F_DIR);
  wire       sel_g_dir  = (bus_req.addr == `PIO_OFS_G_DIR);
  wire       sel_h_dir  = (bus_req.addr == `PIO_OFS_H_DIR);

  // Converter owns one port B pin when its channel lies in 0..7
  wire       chan_on_b = (converter_channel_select < `PIO_B_CHANNELS);
  wire [7:0] analog_b  = chan_on_b ? (8'h01 << converter_channel_select[2:0]) : 8'h00;

  logic [7:0] latch_a, dir_a, oe_a, rv_a;
  logic [7:0] latch_b, dir_b, oe_b, rv_b;
  logic [5:0] latch_c, dir_c, oe_c, rv_c;
  logic [7:0] latch_d, dir_d, oe_d, rv_d;
  logic [7:0] latch_e, dir_e, oe_e, rv_e;
  logic [6:0] latch_f, dir_f, oe_f, rv_f;
  logic [2:0] latch_g, dir_g, oe_g, rv_g;
  logic [1:0] latch_h, dir_h, oe_h, rv_h;
  logic       sysclk_out_enable_reg;
  logic [7:0] rd_next;
  logic [7:0] rd_data_reg;

  // One slice per port; narrow ports simply hold fewer flops
  pio_port #(.W(`PIO_W_A)) u_port_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_a_data),
    .wr_dir_en  (wr & sel_a_dir),
    .wr_val     (wv),
    .pin_in     (pad_in.a),
    .analog     (8'h00),
    .latch_q    (latch_a),
    .dir_q      (dir_a),
    .pin_oe     (oe_a),
    .rd_val     (rv_a)
  );

  pio_port #(.W(`PIO_W_B)) u_port_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_b_data),
    .wr_dir_en  (wr & sel_b_dir),
    .wr_val     (wv),
    .pin_in     (pad_in.b),
    .analog     (analog_b),
    .latch_q    (latch_b),
    .dir_q      (dir_b),
    .pin_oe     (oe_b),
    .rd_val     (rv_b)
  );

  pio_port #(.W(`PIO_W_C)) u_port_c (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_c_data),
    .wr_dir_en  (wr & sel_c_dir),
    .wr_val     (wv[5:0]),
    .pin_in     (pad_in.c),
    .analog     (6'h00),
    .latch_q    (latch_c),
    .dir_q      (dir_c),
    .pin_oe     (oe_c),
    .rd_val     (rv_c)
  );

  pio_port #(.W(`PIO_W_D)) u_port_d (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_d_data),
    .wr_dir_en  (wr & sel_d_dir),
    .wr_val     (wv),
    .pin_in     (pad_in.d),
    .analog     (8'h00),
    .latch_q    (latch_d),
    .dir_q      (dir_d),
    .pin_oe     (oe_d),
    .rd_val     (rv_d)
  );

  pio_port #(.W(`PIO_W_E)) u_port_e (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_e_data),
    .wr_dir_en  (wr & sel_e_dir),
    .wr_val     (wv),
    .pin_in     (pad_in.e),
    .analog     (8'h00),
    .latch_q    (latch_e),
    .dir_q      (dir_e),
    .pin_oe     (oe_e),
    .rd_val     (rv_e)
  );

  pio_port #(.W(`PIO_W_F)) u_port_f (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_f_data),
    .wr_dir_en  (wr & sel_f_dir),
    .wr_val     (wv[6:0]),
    .pin_in     (pad_in.f),
    .analog     (7'h00),
    .latch_q    (latch_f),
    .dir_q      (dir_f),
    .pin_oe     (oe_f),
    .rd_val     (rv_f)
  );

  pio_port #(.W(`PIO_W_G)) u_port_g (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_g_data),
    .wr_dir_en  (wr & sel_g_dir),
    .wr_val     (wv[2:0]),
    .pin_in     (pad_in.g),
    .analog     (3'h0),
    .latch_q    (latch_g),
    .dir_q      (dir_g),
    .pin_oe     (oe_g),
    .rd_val     (rv_g)
  );

  pio_port #(.W(`PIO_W_H)) u_port_h (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_data_en (wr & sel_h_data),
    .wr_dir_en  (wr & sel_h_dir),
    .wr_val     (wv[1:0]),
    .pin_in     (pad_in.h),
    .analog     (2'h0),
    .latch_q    (latch_h),
    .dir_q      (dir_h),
    .pin_oe     (oe_h),
    .rd_val     (rv_h)
  );

  // Clock-out enable lives in bit 7 of the port C direction register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_out_enable_reg <= 1'b0;
    end else if (wr && sel_c_dir) begin
      sysclk_out_enable_reg <= wv[`PIO_SYSCLK_BIT];
    end
  end

  // Pin 2 of port C carries the bus clock while enabled; its own
  // direction bit is ignored then. The pad sees a gated copy of clk,
  // so keep it away from any logic inside this block.
  wire c2_out = sysclk_out_enable_reg ? clk : latch_c[`PIO_SYSCLK_PIN];
  wire c2_oe  = sysclk_out_enable_reg | oe_c[`PIO_SYSCLK_PIN];

  // Fifty pins gathered back into the pad structs
  assign pad_out = {latch_a, latch_b, latch_c[5:3], c2_out, latch_c[1:0],
                    latch_d, latch_e, latch_f, latch_g, latch_h};
  assign pad_oe  = {oe_a, oe_b, oe_c[5:3], c2_oe, oe_c[1:0],
                    oe_d, oe_e, oe_f, oe_g, oe_h};

  // Read select; narrow registers pad with zeros above their bits, except port C direction, whose bit 7 reads the clock-out enable
  always_comb begin
    case (bus_req.addr)
      `PIO_OFS_A_DATA: rd_next = rv_a;
      `PIO_OFS_B_DATA: rd_next = rv_b;
      `PIO_OFS_C_DATA: rd_next = {2'h0, rv_c};
      `PIO_OFS_D_DATA: rd_next = rv_d;
      `PIO_OFS_A_DIR:  rd_next = dir_a;
      `PIO_OFS_B_DIR:  rd_next = dir_b;
      `PIO_OFS_C_DIR:  rd_next = {sysclk_out_enable_reg, 1'b0, dir_c};
      `PIO_OFS_D_DIR:  rd_next = dir_d;
      `PIO_OFS_E_DATA: rd_next = rv_e;
      `PIO_OFS_F_DATA: rd_next = {1'b0, rv_f};
      `PIO_OFS_G_DATA: rd_next = {5'h00, rv_g};
      `PIO_OFS_H_DATA: rd_next = {6'h00, rv_h};
      `PIO_OFS_E_DIR:  rd_next = dir_e;
      `PIO_OFS_F_DIR:  rd_next = {1'b0, dir_f};
      `PIO_OFS_G_DIR:  rd_next = {5'h00, dir_g};
      `PIO_OFS_H_DIR:  rd_next = {6'h00, dir_h};
      default:         rd_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= bus_req.rd ? rd_next : 8'h00;
    end
  end

  assign rd_data = rd_data_reg;

  // Checks on the register port and the pins
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_dir_a_write;
    wr && sel_a_dir;
  endsequence

  sequence s_read_a_all_out;
    bus_req.rd && sel_a_data && (dir_a == 8'hff);
  endsequence

  sequence s_read_a_all_in;
    bus_req.rd && sel_a_data && (dir_a == 8'h00) && !(wr && sel_a_dir);
  endsequence

  a_dir_drives_oe: assert property (
    s_dir_a_write |=> (pad_oe.a == $past(wv))
  ) else $error("port A enables do not follow direction write");

  a_reset_inputs: assert property (
    $rose(rst_n) |-> (pad_oe.a == 8'h00) && (pad_oe.b == 8'h00)
  ) else $error("ports A and B not inputs after reset");

  a_reset_port_c: assert property (
    $rose(rst_n) |-> (pad_oe.c == 6'h00) && !sysclk_out_enable_reg
  ) else $error("port C not inputs after reset");

  a_latch_write: assert property (
    (wr && sel_a_data) |=> (pad_out.a == $past(wv)) ##1 (pad_out.a == $past(wv, 2) || $past(wr && sel_a_data))
  ) else $error("port A latch not updated by write");

  a_read_latch: assert property (
    s_read_a_all_out |=> (rd_data == $past(latch_a))
  ) else $error("output bits do not read the latch");

  a_read_pin: assert property (
    s_read_a_all_in |=> (rd_data == $past(pad_in.a, 3))
  ) else $error("input bits do not read the synchronised pin");

  a_input_ignores_latch: assert property (
    (wr && sel_a_data && dir_a == 8'h00) ##1 (bus_req.rd && sel_a_data && dir_a == 8'h00)
      |=> (rd_data == $past(pad_in.a, 3))
  ) else $error("latch write leaked into input read");

  a_adc_read_zero: assert property (
    (bus_req.rd && sel_b_data && chan_on_b && !dir_b[converter_channel_select[2:0]])
      |=> (rd_data[$past(converter_channel_select[2:0])] == 1'b0)
  ) else $error("converter input bit did not read zero");

  a_adc_no_drive: assert property (
    chan_on_b |-> !pad_oe.b[converter_channel_select[2:0]]
  ) else $error("converter pin is driven");

  a_clk_out_oe: assert property (
    sysclk_out_enable_reg |-> pad_oe.c[`PIO_SYSCLK_PIN]
  ) else $error("clock output pin not driven");

  a_unused_zero: assert property (
    (bus_req.rd && (sel_c_data || sel_h_dir)) |=> (rd_data[7:6] == 2'b00)
  ) else $error("unimplemented bits read nonzero");

  a_unmapped_zero: assert property (
    (bus_req.rd && (bus_req.addr > `PIO_OFS_H_DIR)) |=> (rd_data == 8'h00)
  ) else $error("unmapped read returned data");

  a_sync_delay: assert property (
    (dir_a == 8'h00) [*3] ##0 (bus_req.rd && sel_a_data) |=> (rd_data == $past(pad_in.a, 3))
  ) else $error("pin level not delayed by two stages");

  // Further checks on reads, writes and reset of the whole bank
  a_read_idle_zero: assert property (
    !bus_req.rd |=> (rd_data == 8'h00)
  ) else $error("read data not zero outside a read");

  a_dir_a_read: assert property (
    (bus_req.rd && sel_a_dir) |=> (rd_data == $past(dir_a))
  ) else $error("direction read does not return the register");

  a_reset_all_in: assert property (
    $rose(rst_n) |-> (pad_oe == '0)
  ) else $error("some pin driven right after reset");

  a_b_latch_write: assert property (
    (wr && sel_b_data) |=> (latch_b == $past(wv))
  ) else $error("port B latch not updated by write");

  a_conv_out_latch: assert property (
    (bus_req.rd && sel_b_data && chan_on_b && dir_b[converter_channel_select[2:0]])
      |=> (rd_data[$past(converter_channel_select[2:0])] == $past(latch_b[converter_channel_select[2:0]]))
  ) else $error("converter output bit did not read the latch");

  a_plain_b_oe: assert property (
    !chan_on_b |-> (pad_oe.b == dir_b)
  ) else $error("port B enables differ from direction without converter");

  a_clk_en_write: assert property (
    (wr && sel_c_dir) |=> (sysclk_out_enable_reg == $past(wv[`PIO_SYSCLK_BIT]))
  ) else $error("clock-out enable does not follow its write");

  a_dir_c_write: assert property (
    (wr && sel_c_dir) |=> (dir_c == $past(wv[5:0]))
  ) else $error("port C direction does not follow its write");

  a_port_f_top: assert property (
    (bus_req.rd && (sel_f_data || sel_f_dir)) |=> !rd_data[7]
  ) else $error("port F top bit read nonzero");

  a_port_g_top: assert property (
    (bus_req.rd && (sel_g_data || sel_g_dir)) |=> (rd_data[7:3] == 5'h00)
  ) else $error("port G upper bits read nonzero");

endmodule
`default_nettype wire
